// [hw/vip_probe.sv]
/*
 * Virtual I/O probe end: four optional port groups toward the user design
 * and a control port toward the debug controller hub.
 * Assumes the hub control port is dedicated to this probe, unused monitor
 * bits are tied low by the integrator, and synchronous ports face logic on
 * clk_in.
 */
`default_nettype none

// Overview of operation
// [R1] Optional async monitor inputs, one to 256 wide.
// [R2] Async monitor inputs accept any clock domain.
// [R3] Optional async drive outputs, up to 256.
// [R4] Optional sync monitor inputs sampled on chosen edge.
// [R5] Optional sync drive outputs updated on chosen edge.
// [R6] Build setting picks rising or falling clock edge.
// [R7] Edge setting matters only with sync groups present.
// [R8] Integrator gives probe its own hub port.
// [R9] Integrator ties unused monitor input bits low.
// [R10] Sync monitor sources should share the probe clock.
// [R11] Sync output sinks should share the probe clock.
// [R12] Report inputs on request; hold outputs until rewritten.
// [R13] Async inputs synchronised before being reported.
module vip_probe
   import vip_pkg::*;
#(
   parameter bit          AIN_EN     = 1'b1,  // Async monitor group present
   parameter int unsigned AIN_W      = 256,   // Async monitor width
   parameter bit          AOUT_EN    = 1'b1,  // Async drive group present
   parameter int unsigned AOUT_W     = 256,   // Async drive width
   parameter bit          SIN_EN     = 1'b1,  // Sync monitor group present
   parameter int unsigned SIN_W      = 256,   // Sync monitor width
   parameter bit          SOUT_EN    = 1'b1,  // Sync drive group present
   parameter int unsigned SOUT_W     = 256,   // Sync drive width
   parameter bit          FALL_EDGE  = 1'b0   // Sync groups use falling edge
)
(
   input  wire logic              clk_in,        // Probe clock
   input  wire logic              reset_n_in,    // Synchronous reset, active low
   input  wire logic              clk_en_in,     // Freezes all state when low
   vip_ctl_if.probe               ctl,           // Control port from the hub
   input  wire logic [AIN_W-1:0]  async_in_in,   // Async monitor inputs
   output logic      [AOUT_W-1:0] async_out_out, // Async drive outputs
   input  wire logic [SIN_W-1:0]  sync_in_in,    // Sync monitor inputs
   output logic      [SOUT_W-1:0] sync_out_out   // Sync drive outputs
);

   localparam int unsigned N_WORDS = MAX_W / WORD_W;

   // ------------------------------------------------------------------
   // Control-port decode
   // ------------------------------------------------------------------
   logic [AIN_W-1:0]  ain_meta_q;
   logic [AIN_W-1:0]  ain_sync_q;
   logic [MAX_W-1:0]  aout_q;
   logic [MAX_W-1:0]  sout_shadow_q;
   logic [MAX_W-1:0]  sout_q;
   logic [SIN_W-1:0]  sin_cap_q;
   logic [WORD_W-1:0] rdata_q;
   logic              rvalid_q;

   // Group selects. A write to an input group or to an absent group matches
   // no register and is dropped.
   wire              sel_ain  = (ctl.grp == GRP_AIN);
   wire              sel_aout = (ctl.grp == GRP_AOUT);
   wire              sel_sin  = (ctl.grp == GRP_SIN);
   wire              sel_sout = (ctl.grp == GRP_SOUT);
   wire              wr_aout  = ctl.wr && sel_aout && AOUT_EN;
   wire              wr_sout  = ctl.wr && sel_sout && SOUT_EN;
   wire [N_WORDS-1:0] word_hit;

   wire [MAX_W-1:0] ain_view  = AIN_EN  ? MAX_W'(ain_sync_q) : '0;
   wire [MAX_W-1:0] aout_view = AOUT_EN ? MAX_W'(aout_q[AOUT_W-1:0]) : '0;
   wire [MAX_W-1:0] sin_view  = SIN_EN  ? MAX_W'(sin_cap_q) : '0;
   wire [MAX_W-1:0] sout_view = SOUT_EN ? MAX_W'(sout_q[SOUT_W-1:0]) : '0;

   wire [MAX_W-1:0] grp_view = sel_ain  ? ain_view  :
                               sel_aout ? aout_view :
                               sel_sin  ? sin_view  :
                               sel_sout ? sout_view : '0;
   wire [BASE_W-1:0] rbase   = {ctl.idx, WORD_LSB_ZERO};
   wire [WORD_W-1:0] rd_word = grp_view[rbase +: WORD_W];

   // ------------------------------------------------------------------
   // Async monitor synchroniser
   // ------------------------------------------------------------------
   // Two stages into clk_in; only the second stage is ever read.
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         ain_meta_q <= '0;
         ain_sync_q <= '0;
      end else if (clk_en_in && AIN_EN) begin
         ain_meta_q <= async_in_in;  // [R1] [R2]
         ain_sync_q <= ain_meta_q;   // [R13]
      end
   end

   // ------------------------------------------------------------------
   // Drive registers written by the hub
   // ------------------------------------------------------------------
   // Each 32-bit word holds its value until the hub writes that word again.
   genvar w;
   generate
      for (w = 0; w < N_WORDS; w++) begin : g_word
         assign word_hit[w] = (ctl.idx == IDX_W'(w));

         always_ff @(posedge clk_in) begin
            if (!reset_n_in) begin
               aout_q[w*WORD_W +: WORD_W] <= RESET_WORD;
            end else if (clk_en_in && wr_aout && word_hit[w]) begin
               aout_q[w*WORD_W +: WORD_W] <= ctl.wdata;         // [R3] [R12]
            end
         end

         // The sync group is staged here on the hub's edge and moved to the
         // pins only on the selected edge, so its pins never change elsewhere.
         always_ff @(posedge clk_in) begin
            if (!reset_n_in) begin
               sout_shadow_q[w*WORD_W +: WORD_W] <= RESET_WORD;
            end else if (clk_en_in && wr_sout && word_hit[w]) begin
               sout_shadow_q[w*WORD_W +: WORD_W] <= ctl.wdata;  // [R12]
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // Synchronous groups on the selected edge
   // ------------------------------------------------------------------
   // Without either sync group these signals are tied to zero, so the edge
   // choice leaves no trace in the netlist.
   localparam bit SYNC_USED = SIN_EN || SOUT_EN;

   generate
      if (SYNC_USED && FALL_EDGE) begin : g_fall                // [R6] [R7]
         // Drive values reach user logic half a cycle after the hub's write
         // lands, and monitor values are taken half a cycle before the
         // rising edge.
         always_ff @(negedge clk_in) begin
            if (!reset_n_in) begin
               sin_cap_q <= '0;
            end else if (clk_en_in && SIN_EN) begin
               sin_cap_q <= sync_in_in;                         // [R4] [R10]
            end
         end

         always_ff @(negedge clk_in) begin
            if (!reset_n_in) begin
               sout_q <= '0;
            end else if (clk_en_in && SOUT_EN) begin
               sout_q <= sout_shadow_q;                         // [R5] [R11]
            end
         end
      end else if (SYNC_USED) begin : g_rise                    // [R6] [R7]
         always_ff @(posedge clk_in) begin
            if (!reset_n_in) begin
               sin_cap_q <= '0;
            end else if (clk_en_in && SIN_EN) begin
               sin_cap_q <= sync_in_in;                         // [R4] [R10]
            end
         end

         always_ff @(posedge clk_in) begin
            if (!reset_n_in) begin
               sout_q <= '0;
            end else if (clk_en_in && SOUT_EN) begin
               sout_q <= sout_shadow_q;                         // [R5] [R11]
            end
         end
      end else begin : g_none                                   // [R7]
         // Nothing here is clocked, so the edge setting has no effect.
         assign sin_cap_q = '0;
         assign sout_q    = '0;
      end
   endgenerate

   // ------------------------------------------------------------------
   // Read answer to the hub
   // ------------------------------------------------------------------
   // Unused monitor bits are expected tied low, so they read as zero too.
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         rvalid_q <= 1'b0;
      end else if (clk_en_in) begin
         rvalid_q <= ctl.rd;
      end
   end

   // The read word is taken once per request and held for the hub.
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         rdata_q <= RESET_WORD;
      end else if (clk_en_in && ctl.rd) begin
         rdata_q <= rd_word;                                    // [R12] [R9]
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // The answer strobe is masked by the clock enable so that a frozen probe
   // never shows the hub a second answer for one request.
   assign ctl.rdata     = rdata_q;
   assign ctl.rvalid    = rvalid_q && clk_en_in;
   assign async_out_out = AOUT_EN ? aout_q[AOUT_W-1:0] : '0;
   assign sync_out_out  = SOUT_EN ? sout_q[SOUT_W-1:0] : '0;

endmodule

`default_nettype wire

// [hw/vip_pkg.sv]
/*
 * Shared constants of the virtual I/O probe and its debug controller hub:
 * control-port group codes, word layout and the hub's register map.
 * Assumes both ends run on one clock and include this package first.
 */
`default_nettype none

package vip_pkg;

   // ------------------------------------------------------------------
   // Control-port layout
   // ------------------------------------------------------------------
   localparam int unsigned WORD_W    = 32;
   localparam int unsigned MAX_W     = 256;
   localparam int unsigned IDX_W     = 3;
   localparam int unsigned GRP_W     = 2;
   localparam int unsigned BASE_W    = 8;

   localparam logic [1:0]  GRP_AIN   = 2'h0;
   localparam logic [1:0]  GRP_AOUT  = 2'h1;
   localparam logic [1:0]  GRP_SIN   = 2'h2;
   localparam logic [1:0]  GRP_SOUT  = 2'h3;

   localparam logic [4:0]  WORD_LSB_ZERO = 5'h00;

   // ------------------------------------------------------------------
   // Hub register map
   // ------------------------------------------------------------------
   localparam int unsigned ADDR_W    = 8;
   localparam logic [7:0]  REG_CMD    = 8'h00;
   localparam logic [7:0]  REG_WDATA  = 8'h04;
   localparam logic [7:0]  REG_RDATA  = 8'h08;
   localparam logic [7:0]  REG_STATUS = 8'h0c;

   localparam int unsigned CMD_START_BIT = 0;
   localparam int unsigned CMD_WRITE_BIT = 1;
   localparam int unsigned CMD_GRP_LSB   = 2;
   localparam int unsigned CMD_IDX_LSB   = 4;

   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_DONE_BIT = 1;

   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   typedef enum logic [1:0] {
      VIP_IDLE,
      VIP_ISSUE,
      VIP_WAIT
   } vip_hub_state_t;

endpackage

`default_nettype wire

// [hw/vip_ctl_if.sv]
/*
 * Control port between the debug controller hub and one probe.
 * Assumes a single shared clock; one hub port serves exactly one probe.
 */
`default_nettype none

interface vip_ctl_if;
   import vip_pkg::*;

   logic              wr;
   logic              rd;
   logic [GRP_W-1:0]  grp;
   logic [IDX_W-1:0]  idx;
   logic [WORD_W-1:0] wdata;
   logic [WORD_W-1:0] rdata;
   logic              rvalid;

   modport probe (
      input  wr,
      input  rd,
      input  grp,
      input  idx,
      input  wdata,
      output rdata,
      output rvalid
   );

   modport hub (
      output wr,
      output rd,
      output grp,
      output idx,
      output wdata,
      input  rdata,
      input  rvalid
   );

endinterface

`default_nettype wire

// [hw/vip_hub.sv]
/*
 * Debug controller hub end: takes commands over a plain register port and
 * runs one probe access at a time over the control port.
 * Assumes its control port is wired to one probe only.
 */
`default_nettype none

module vip_hub
   import vip_pkg::*;
(
   input  wire logic              clk_in,      // System clock
   input  wire logic              reset_n_in,  // Synchronous reset, active low
   input  wire logic              clk_en_in,   // Freezes all state when low
   input  wire logic [ADDR_W-1:0] addr_in,     // Register byte address
   input  wire logic [31:0]       wdata_in,    // Register write data
   input  wire logic              wr_in,       // Write strobe
   input  wire logic              rd_in,       // Read strobe
   output logic      [31:0]       rdata_out,   // Read data, cycle after rd_in
   vip_ctl_if.hub                 ctl          // Control port to the probe
);

   // ------------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------------
   vip_hub_state_t    state_q;
   vip_hub_state_t    state_d;
   logic              op_wr_q;
   logic [GRP_W-1:0]  grp_q;
   logic [IDX_W-1:0]  idx_q;
   logic [31:0]       wdata_q;
   logic [31:0]       rdata_q;
   logic              done_q;
   logic [31:0]       rd_mux_q;

   wire busy      = (state_q != VIP_IDLE);
   wire cmd_wr    = wr_in && (addr_in == REG_CMD);
   wire start     = cmd_wr && wdata_in[CMD_START_BIT] && !busy;
   wire finish    = (state_q == VIP_ISSUE && op_wr_q) ||
                    (state_q == VIP_WAIT && ctl.rvalid);
   wire [31:0] status_word = {30'h0, done_q, busy};
   wire [31:0] rd_sel = (addr_in == REG_WDATA)  ? wdata_q :
                        (addr_in == REG_RDATA)  ? rdata_q :
                        (addr_in == REG_STATUS) ? status_word : RESET_WORD;

   always_comb begin
      state_d = state_q;
      case (state_q)
         VIP_IDLE:  if (start) state_d = VIP_ISSUE;
         VIP_ISSUE: state_d = op_wr_q ? VIP_IDLE : VIP_WAIT;
         VIP_WAIT:  if (ctl.rvalid) state_d = VIP_IDLE;
         default:   state_d = VIP_IDLE;
      endcase
   end

   // ------------------------------------------------------------------
   // State and registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         state_q  <= VIP_IDLE;
         op_wr_q  <= 1'b0;
         grp_q    <= '0;
         idx_q    <= '0;
         wdata_q  <= RESET_WORD;
         rdata_q  <= RESET_WORD;
         done_q   <= 1'b0;
         rd_mux_q <= RESET_WORD;
      end else if (clk_en_in) begin
         state_q <= state_d;
         if (start) begin
            op_wr_q <= wdata_in[CMD_WRITE_BIT];
            grp_q   <= wdata_in[CMD_GRP_LSB +: GRP_W];
            idx_q   <= wdata_in[CMD_IDX_LSB +: IDX_W];
         end
         if (wr_in && addr_in == REG_WDATA && !busy) wdata_q <= wdata_in;
         if (state_q == VIP_WAIT && ctl.rvalid) rdata_q <= ctl.rdata; // [R12]
         // Completion sets done; only a new start clears it.
         if (finish) done_q <= 1'b1;
         else if (start) done_q <= 1'b0;
         if (rd_in) rd_mux_q <= rd_sel;
      end
   end

   // ------------------------------------------------------------------
   // Control port drive
   // ------------------------------------------------------------------
   assign ctl.wr    = (state_q == VIP_ISSUE) && op_wr_q && clk_en_in;  // [R8]
   assign ctl.rd    = (state_q == VIP_ISSUE) && !op_wr_q && clk_en_in;
   assign ctl.grp   = grp_q;
   assign ctl.idx   = idx_q;
   assign ctl.wdata = wdata_q;
   assign rdata_out = rd_mux_q;

endmodule

`default_nettype wire

// [sim/vip_probe_properties.sv]
/* Checker for the control port between hub and probe.
   Assumes one shared clock with the clock enable held high. */
`default_nettype none

module vip_probe_properties
   import vip_pkg::*;
#(
   parameter int unsigned AIN_W = 256,  // Async monitor width
   parameter int unsigned SIN_W = 256   // Sync monitor width
)
(
   input wire logic              clk_in,      // Clock
   input wire logic              reset_n_in,  // Reset, active low
   input wire logic              wr,          // Probe write
   input wire logic              rd,          // Probe read
   input wire logic [GRP_W-1:0]  grp,         // Group code
   input wire logic [IDX_W-1:0]  idx,         // Word index
   input wire logic [WORD_W-1:0] rdata,       // Read word
   input wire logic              rvalid       // Read answer
);
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------------
   // Control port properties
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);

   sequence rd_req;
      rd;
   endsequence

   sequence answer;
      ##1 rvalid ##1 !rvalid;
   endsequence

   answer_timing_a: assert property (rd_req |-> answer)
      else $error("read answer not one cycle after request");
   answer_cause_a: assert property (rvalid |-> $past(rd))
      else $error("read answer without request");
   req_exclusive_a: assert property (!(wr && rd))
      else $error("write and read together");
   req_spacing_a: assert property ((wr || rd) |=> !(wr || rd))
      else $error("requests back to back");
   rdata_hold_a: assert property (!rvalid |-> $stable(rdata))
      else $error("read word changed without answer");
   addr_hold_a: assert property (rvalid |-> $stable(grp) && $stable(idx))
      else $error("address moved during answer");
   ain_above_a: assert property (rvalid && $past(grp) == GRP_AIN &&
      $past(idx) * WORD_W >= AIN_W |-> rdata == '0)
      else $error("async monitor bits above width not zero");
   sin_above_a: assert property (rvalid && $past(grp) == GRP_SIN &&
      $past(idx) * WORD_W >= SIN_W |-> rdata == '0)
      else $error("sync monitor bits above width not zero");
endmodule

`default_nettype wire

// [sim/vip_probe_tb.sv]
/* Testbench joining hub and probe; drives the hub register port.
   Assumes one clock and clock enable held high; two hub and probe pairs
   share the register port, one with rising-edge and one with falling-edge
   sync groups. */
`default_nettype none

module vip_probe_tb;
   import vip_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int unsigned W = 40;

   logic              clk_in     = 1'b0;
   logic              reset_n_in = 1'b0;
   logic [ADDR_W-1:0] addr       = 8'h00;
   logic [31:0]       wdata      = 32'h0000_0000;
   logic              wr         = 1'b0;
   logic              rd         = 1'b0;
   logic [31:0]       rdata_out;
   logic [W-1:0]      ain        = 40'h00_0000_0000;
   logic [W-1:0]      sin        = 40'h00_0000_0000;
   logic [W-1:0]      aout;
   logic [W-1:0]      sout;
   logic [31:0]       rdata_f;
   logic [31:0]       q_f        = 32'h0000_0000;
   logic [W-1:0]      sout_f;
   int                n_mismatch = 0;
   int                n_tests    = 0;

   always #20 clk_in = ~clk_in;

   vip_ctl_if i_vip_ctl_if ();

   vip_hub i_vip_hub (.clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(1'b1),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdata_out), .ctl(i_vip_ctl_if));

   vip_probe #(.AIN_W(W), .AOUT_W(W), .SIN_W(W), .SOUT_W(W)) i_vip_probe (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(1'b1), .ctl(i_vip_ctl_if),
      .async_in_in(ain), .async_out_out(aout), .sync_in_in(sin), .sync_out_out(sout));

   // Second pair on the same register port, sync groups on the falling edge.
   vip_ctl_if i_vip_ctl_if_f ();

   vip_hub i_vip_hub_f (.clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(1'b1),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdata_f), .ctl(i_vip_ctl_if_f));

   vip_probe #(.AIN_W(W), .AOUT_W(W), .SIN_W(W), .SOUT_W(W),
      .FALL_EDGE(1'b1)) i_vip_probe_f (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(1'b1), .ctl(i_vip_ctl_if_f),
      .async_in_in(ain), .async_out_out(), .sync_in_in(sin), .sync_out_out(sout_f));

   vip_probe_properties #(.AIN_W(W), .SIN_W(W)) i_vip_probe_properties (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .wr(i_vip_ctl_if.wr),
      .rd(i_vip_ctl_if.rd), .grp(i_vip_ctl_if.grp), .idx(i_vip_ctl_if.idx),
      .rdata(i_vip_ctl_if.rdata), .rvalid(i_vip_ctl_if.rvalid));

   // ------------------------------------------------------------------
   // Register port tasks
   // ------------------------------------------------------------------
   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_in);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 d = rdata_out;
      q_f = rdata_f;
   endtask

   // Polls for done with busy low; a stuck operation ends the run.
   task automatic wait_done();
      logic [31:0] s;
      for (int i = 0; i < 20; i++) begin
         reg_rd(REG_STATUS, s);
         if (s[1:0] === 2'b10) return;
      end
      n_mismatch++;
      stop_test();
   endtask

   task automatic probe_op(input logic w, input logic [1:0] g, input logic [2:0] i,
                           input logic [31:0] d, output logic [31:0] q);
      if (w) reg_wr(REG_WDATA, d);
      reg_wr(REG_CMD, {25'h0, i, g, w, 1'b1});
      wait_done();
      reg_rd(REG_RDATA, q);
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   initial begin
      logic [31:0] q;
      repeat (20) @(posedge clk_in);
      reset_n_in <= 1'b1;
      reg_rd(REG_STATUS, q);
      chk({8'h00, q}, 40'h00_0000_0000);
      probe_op(1'b1, GRP_AOUT, 3'h0, 32'hdead_beef, q);
      probe_op(1'b1, GRP_AOUT, 3'h1, 32'h0000_00a5, q);
      chk(aout, 40'ha5_dead_beef);
      probe_op(1'b1, GRP_SOUT, 3'h1, 32'h0000_003c, q);
      probe_op(1'b1, GRP_SOUT, 3'h0, 32'h1234_5678, q);
      chk(sout, 40'h3c_1234_5678);
      chk(sout_f, 40'h3c_1234_5678);
      chk(aout, 40'ha5_dead_beef);
      // The falling-edge pair moves a new word out half a cycle earlier.
      reg_wr(REG_WDATA, 32'h0000_0000);
      reg_wr(REG_CMD, {25'h0, 3'h0, GRP_SOUT, 1'b1, 1'b1});
      @(posedge clk_in);
      @(negedge clk_in);
      #1;
      chk(sout_f, 40'h3c_0000_0000);
      chk(sout, 40'h3c_1234_5678);
      wait_done();
      chk(sout, 40'h3c_0000_0000);
      @(posedge clk_in);
      ain <= 40'h5a_0f0f_f0f0;
      sin <= 40'hc3_8765_4321;
      for (int i = 0; i < 3; i++) begin
         probe_op(1'b0, GRP_AIN, 3'(i), 32'h0000_0000, q);
         chk({8'h00, q}, {8'h00, 32'(ain >> (32 * i))});
         probe_op(1'b0, GRP_SIN, 3'(i), 32'h0000_0000, q);
         chk({8'h00, q}, {8'h00, 32'(sin >> (32 * i))});
         chk({8'h00, q_f}, {8'h00, 32'(sin >> (32 * i))});
      end
      // Read-only and unmapped places must not take writes.
      reg_wr(REG_RDATA, 32'hffff_ffff);
      reg_rd(REG_RDATA, q);
      chk({8'h00, q}, 40'h00_0000_0000);
      reg_wr(8'h10, 32'hffff_ffff);
      reg_rd(8'h10, q);
      chk({8'h00, q}, 40'h00_0000_0000);
      stop_test();
   end
endmodule

`default_nettype wire
